// [hw/socket_power_irq_ctrl.v]
// Per-socket power, reset, card kind and interrupt routing registers
`timescale 1ns/10ps
`default_nettype none
`include "socket_ctrl_defines.vh"

module socket_power_irq_ctrl (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Reset and power-event pins
   input wire global_reset_in_n,
   input wire bus_reset_in_n,
   input wire power_event_enable,
   // Configuration-space routing control
   input wire change_route_ctrl,
   // Register window access
   input wire [11:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   output reg reg_ack,
   // Card pins, per socket
   input wire [1:0] card_is_32bit,
   input wire [1:0] battery_ring_pin,
   input wire [1:0] card_ireq_n,
   input wire [1:0] card_status_change,
   // Card side controls, per socket
   output reg [1:0] card_output_enable,
   output reg [1:0] card_reset_out,
   output reg [1:0] card_kind_select,
   output reg [1:0] ring_indicate,
   // Power switch interface
   output reg [3:0] card_supply_request,
   output reg [3:0] prog_voltage_request,
   output reg [1:0] socket_power_state,
   output reg [1:0] power_req_update,
   // Interrupt routing
   output reg [1:0] status_change_bus_route,
   output reg [1:0] status_change_bus_irq,
   output reg [15:0] legacy_irq,
   output reg system_mgmt_interrupt
);

   localparam NSYNC = 9;

   reg rst_meta_r;
   reg rst_sync_r;
   wire rst_int_n;

   reg [NSYNC-1:0] pin_meta_r;
   reg [NSYNC-1:0] pin_sync_r;
   wire [NSYNC-1:0] pin_raw;

   wire glob_clr_s;
   wire bus_clr_s;
   wire event_en_s;
   wire [1:0] is32_s;
   wire [1:0] ring_s;
   wire [1:0] ireq_s;

   wire clr_marked;
   wire clr_any;

   wire in_window;
   wire [5:0] idx;
   wire sock;

   wire [7:0] pwr_r [0:1];
   wire [7:0] irq_r [0:1];
   wire [1:0] supply_chg;
   wire [1:0] pwr_wr;
   wire [1:0] irq_wr;
   wire [1:0] power_on;

   reg [7:0] rdata_nxt;
   reg [15:0] legacy_nxt;
   reg mgmt_irq_nxt;
   reg [3:0] sel;
   integer s;

   // Reset release through two flip-flops
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   assign rst_int_n = rst_sync_r;

   // All pins except card_status_change cross in one vector; bits are unrelated levels
   assign pin_raw = {card_ireq_n, battery_ring_pin, card_is_32bit,
      power_event_enable, bus_reset_in_n, global_reset_in_n};

   always @(posedge clk or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         pin_meta_r <= `PIN_IDLE;
         pin_sync_r <= `PIN_IDLE;
      end
      else
      begin
         pin_meta_r <= pin_raw;
         pin_sync_r <= pin_meta_r;
      end
   end

   assign glob_clr_s = ~pin_sync_r[0];
   assign bus_clr_s = ~pin_sync_r[1];
   assign event_en_s = pin_sync_r[2];
   assign is32_s = pin_sync_r[4:3];
   assign ring_s = pin_sync_r[6:5];
   assign ireq_s = ~pin_sync_r[8:7];

   // global reset always, bus reset only without events
   assign clr_marked = glob_clr_s | (bus_clr_s & ~event_en_s);
   assign clr_any = glob_clr_s | bus_clr_s;

   // window decode, socket select by address bit 6
   assign in_window = reg_addr[11:7] == `WIN_HI_CODE;
   assign idx = reg_addr[5:0];
   assign sock = reg_addr[6];

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : sk
         assign pwr_wr[g] = reg_wr && in_window && (sock == g) &&
            (idx == `IDX_POWER);
         assign irq_wr[g] = reg_wr && in_window && (sock == g) &&
            (idx == `IDX_IRQ_GEN);

         socket_reg_pair u_regs (
            .clk(clk),
            .rst_n(rst_int_n),
            .clr_any(clr_any),
            .clr_marked(clr_marked),
            .pwr_wr(pwr_wr[g]),
            .irq_wr(irq_wr[g]),
            .wdata(reg_wdata),
            .pwr_r(pwr_r[g]),
            .irq_r(irq_r[g]),
            .supply_chg_r(supply_chg[g])
         );

         // only 5 V and 3 V codes power the socket
         assign power_on[g] =
            (pwr_r[g][`PWR_VCC_HI:`PWR_VCC_LO] == `VCC_5V) ||
            (pwr_r[g][`PWR_VCC_HI:`PWR_VCC_LO] == `VCC_3V);

         always @(posedge clk or negedge rst_int_n)
         begin
            if (!rst_int_n)
            begin
               card_output_enable[g] <= 1'b0;
               card_reset_out[g] <= 1'b0;
               card_kind_select[g] <= 1'b0;
               ring_indicate[g] <= 1'b0;
               card_supply_request[2*g+1:2*g] <= `VCC_OFF;
               prog_voltage_request[2*g+1:2*g] <= `VPP_OFF;
               socket_power_state[g] <= 1'b0;
               power_req_update[g] <= 1'b0;
               status_change_bus_route[g] <= 1'b0;
               status_change_bus_irq[g] <= 1'b0;
            end
            else
            begin
               card_output_enable[g] <= pwr_r[g][`PWR_OE_BIT];
               // reset held until bit 6 set, 16-bit only
               card_reset_out[g] <= ~irq_r[g][`IRQ_RST_BIT] & ~is32_s[g];
               card_kind_select[g] <= irq_r[g][`IRQ_KIND_BIT];
               ring_indicate[g] <= irq_r[g][`IRQ_RING_BIT] & ring_s[g];
               // forwarded two cycles after the write
               card_supply_request[2*g+1:2*g] <=
                  power_on[g] ? pwr_r[g][`PWR_VCC_HI:`PWR_VCC_LO] :
                  `VCC_OFF;
               // prog request ignored while supply off
               prog_voltage_request[2*g+1:2*g] <=
                  (power_on[g] &&
                  pwr_r[g][`PWR_VPP_HI:`PWR_VPP_LO] != `VPP_OFF_RSVD) ?
                  pwr_r[g][`PWR_VPP_HI:`PWR_VPP_LO] : `VPP_OFF;
               socket_power_state[g] <= power_on[g];
               power_req_update[g] <= supply_chg[g];
               // route bit used when control is 0
               // route bit ignored when control is 1
               // empty select also routes to bus
               status_change_bus_route[g] <=
                  (~change_route_ctrl & irq_r[g][`IRQ_ROUTE_BIT]) |
                  (irq_r[g][`IRQ_SEL_HI:`IRQ_SEL_LO] == `SEL_NONE);
               status_change_bus_irq[g] <= card_status_change[g] &
                  ((~change_route_ctrl & irq_r[g][`IRQ_ROUTE_BIT]) |
                  (irq_r[g][`IRQ_SEL_HI:`IRQ_SEL_LO] == `SEL_NONE));
            end
         end
      end
   endgenerate

   // Functional interrupts of I/O cards onto the selected line
   always @*
   begin
      legacy_nxt = 16'h0000;
      mgmt_irq_nxt = 1'b0;
      sel = 4'h0;
      for (s = 0; s < 2; s = s + 1)
      begin
         sel = irq_r[s][`IRQ_SEL_HI:`IRQ_SEL_LO];
         // only I/O cards raise functional interrupts
         if (irq_r[s][`IRQ_KIND_BIT] && ireq_s[s])
         begin
            // code 0010 is system management, 0000 is none, others by number
            if (sel == `SEL_MGMT)
            begin
               mgmt_irq_nxt = 1'b1;
            end
            else if (sel != `SEL_NONE)
            begin
               legacy_nxt[sel] = 1'b1;
            end
         end
      end
   end

   always @(posedge clk or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         legacy_irq <= 16'h0000;
         system_mgmt_interrupt <= 1'b0;
      end
      else
      begin
         legacy_irq <= legacy_nxt;
         system_mgmt_interrupt <= mgmt_irq_nxt;
      end
   end

   // Read mux; unmapped indices read zero
   always @*
   begin
      rdata_nxt = 8'h00;
      if (in_window)
      begin
         case (idx)
            `IDX_IF_STATUS:
            begin
               rdata_nxt[`STAT_POWER_BIT] =
                  sock ? power_on[1] : power_on[0];
            end
            `IDX_POWER:
            begin
               // reserved bits read as stored zeros
               rdata_nxt = sock ? pwr_r[1] : pwr_r[0];
            end
            `IDX_IRQ_GEN:
            begin
               rdata_nxt = sock ? irq_r[1] : irq_r[0];
            end
            default:
            begin
               rdata_nxt = 8'h00;
            end
         endcase
      end
   end

   // Answer one cycle after each access; data held until the next read
   always @(posedge clk or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         reg_rdata <= 8'h00;
         reg_ack <= 1'b0;
      end
      else
      begin
         reg_ack <= reg_rd | reg_wr;
         if (reg_rd)
         begin
            reg_rdata <= rdata_nxt;
         end
      end
   end

endmodule
`default_nettype wire

// [hw/socket_reg_pair.v]
// Power and interrupt/general control registers of one socket
`timescale 1ns/10ps
`default_nettype none
`include "socket_ctrl_defines.vh"

module socket_reg_pair (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Reset sources
   input wire clr_any,
   input wire clr_marked,
   // Write strobes and data
   input wire pwr_wr,
   input wire irq_wr,
   input wire [7:0] wdata,
   // Register contents
   output reg [7:0] pwr_r,
   output reg [7:0] irq_r,
   output reg supply_chg_r
);

   reg [7:0] pwr_nxt;
   reg [7:0] irq_nxt;
   reg supply_chg_nxt;
   reg [7:0] keep_mask;

   always @*
   begin
      keep_mask = 8'hFF;
      if (clr_marked)
      begin
         keep_mask = keep_mask & ~`PWR_MARKED;
      end
      if (clr_any)
      begin
         keep_mask = keep_mask & `PWR_MARKED;
      end
      pwr_nxt = pwr_r & keep_mask;
      irq_nxt = irq_r & ((clr_marked ? ~`IRQ_MARKED : 8'hFF) &
         (clr_any ? `IRQ_MARKED : 8'hFF));
      supply_chg_nxt = 1'b0;
      // Reset has priority; a write in a reset cycle is dropped
      if (pwr_wr && !clr_any && !clr_marked)
      begin
         pwr_nxt = wdata & `PWR_WMASK;
         supply_chg_nxt = ((wdata[4:0] ^ pwr_r[4:0]) & `PWR_REQ_MASK) !=
            5'h00;
      end
      if (irq_wr && !clr_any && !clr_marked)
      begin
         irq_nxt = wdata & `IRQ_WMASK;
      end
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pwr_r <= `PWR_RESET;
         irq_r <= `IRQ_RESET;
         supply_chg_r <= 1'b0;
      end
      else
      begin
         pwr_r <= pwr_nxt;
         irq_r <= irq_nxt;
         supply_chg_r <= supply_chg_nxt;
      end
   end

endmodule
`default_nettype wire

// [include/socket_ctrl_defines.vh]
// Offsets, field positions, reset values and codes of the socket registers
`ifndef SOCKET_CTRL_DEFINES_VH
`define SOCKET_CTRL_DEFINES_VH

// Window decode: offset 0x800 within the socket space, 0x40 per socket
`define WIN_BASE 12'h800
`define WIN_HI_CODE 5'h10
`define SOCKET_STRIDE 7'h40

// Register indices within one socket copy
`define IDX_IF_STATUS 6'h01
`define IDX_POWER 6'h02
`define IDX_IRQ_GEN 6'h03

// Power register fields
`define PWR_OE_BIT 7
`define PWR_VCC_HI 4
`define PWR_VCC_LO 3
`define PWR_VPP_HI 1
`define PWR_VPP_LO 0
`define PWR_WMASK 8'h9B
`define PWR_MARKED 8'h9B
`define PWR_RESET 8'h00
`define PWR_REQ_MASK 5'h1B

// Synchroniser idle levels: requests, resets and event enable high
`define PIN_IDLE 9'h187

// Interrupt and general control fields
`define IRQ_RING_BIT 7
`define IRQ_RST_BIT 6
`define IRQ_KIND_BIT 5
`define IRQ_ROUTE_BIT 4
`define IRQ_SEL_HI 3
`define IRQ_SEL_LO 0
`define IRQ_WMASK 8'hFF
`define IRQ_MARKED 8'h60
`define IRQ_RESET 8'h00

// Interface status field
`define STAT_POWER_BIT 6

// Supply request codes
`define VCC_OFF 2'h0
`define VCC_OFF_RSVD 2'h1
`define VCC_5V 2'h2
`define VCC_3V 2'h3

// Programming voltage codes
`define VPP_OFF 2'h0
`define VPP_VCC 2'h1
`define VPP_12V 2'h2
`define VPP_OFF_RSVD 2'h3

// Functional interrupt line codes
`define SEL_NONE 4'h0
`define SEL_MGMT 4'h2

`endif

// [test/card_model.sv]
// Behavioural 16- or 32-bit card in each socket, steered by bench knobs
`timescale 1ns/10ps
`default_nettype none
module card_model (
   // Bench knobs
   input wire logic [1:0] want_32,
   input wire logic [1:0] want_ring,
   input wire logic [1:0] want_irq,
   input wire logic [1:0] want_chg,
   // From the socket
   input wire logic [1:0] card_reset_out,
   // Card pins
   output logic [1:0] card_is_32bit,
   output logic [1:0] battery_ring_pin,
   output logic [1:0] card_ireq_n,
   output logic [1:0] card_status_change
);
   assign card_is_32bit = want_32;
   assign battery_ring_pin = want_ring;
   // A card held in reset cannot raise its request
   assign card_ireq_n = ~(want_irq & ~card_reset_out);
   assign card_status_change = want_chg;
endmodule
`default_nettype wire

// [test/socket_ctrl_assertions.sv]
// Port-level checks for the socket power and interrupt registers
`timescale 1ns/10ps
`default_nettype none
module socket_ctrl_checker (
   // Clock, reset and register port
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [11:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_ack,
   // Card side
   input wire logic [1:0] card_is_32bit,
   input wire logic [1:0] battery_ring_pin,
   input wire logic [1:0] card_status_change,
   input wire logic [1:0] card_output_enable,
   input wire logic [1:0] card_reset_out,
   input wire logic [1:0] ring_indicate,
   // Power switch and interrupts
   input wire logic [3:0] card_supply_request,
   input wire logic [3:0] prog_voltage_request,
   input wire logic [1:0] socket_power_state,
   input wire logic [1:0] power_req_update,
   input wire logic [1:0] status_change_bus_irq,
   input wire logic [15:0] legacy_irq
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   ack_follow_a: assert property ((reg_wr || reg_rd) |=> reg_ack)
      else $error("access not acknowledged");
   ack_idle_a: assert property (!(reg_wr || reg_rd) |=> !reg_ack)
      else $error("acknowledge without access");
   pwr_rsvd_a: assert property (
      reg_rd && reg_addr[11:7] == 5'h10 && reg_addr[5:0] == 6'h02
      |=> reg_rdata[6:5] == 2'h0 && !reg_rdata[2])
      else $error("reserved power bits read non-zero");
   oe_clear_a: assert property (
      reg_wr && reg_addr == 12'h802 && !reg_wdata[7]
      |=> ##1 !card_output_enable[0])
      else $error("outputs enabled after clearing enable");
   vcc_state_a: assert property (
      socket_power_state == {card_supply_request[3], card_supply_request[1]}
      && (card_supply_request & 4'h5 & ~(card_supply_request >> 1)) == 4'h0)
      else $error("supply code and power state disagree");
   vpp_gate_a: assert property (prog_voltage_request[1:0] != 2'h0
      |-> card_supply_request[1] && prog_voltage_request[1:0] != 2'h3)
      else $error("programming voltage without supply");
   card_rst_a: assert property (card_is_32bit[0] [*6]
      |-> !card_reset_out[0])
      else $error("reset driven to a 32-bit card");
   ring_off_a: assert property ((!battery_ring_pin[0]) [*6]
      |-> !ring_indicate[0])
      else $error("ring seen with pin low");
   chg_irq_a: assert property (status_change_bus_irq[0]
      |-> $past(card_status_change[0]))
      else $error("bus interrupt without status change");
   irq_line_a: assert property (!legacy_irq[0] && !legacy_irq[2])
      else $error("reserved legacy line driven");
   upd_cause_a: assert property (power_req_update[0]
      |-> $past(reg_wr, 2))
      else $error("power update without a write");
endmodule
bind socket_power_irq_ctrl socket_ctrl_checker chk_u (.clk, .rst_n,
   .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_ack,
   .card_is_32bit, .battery_ring_pin, .card_status_change,
   .card_output_enable, .card_reset_out, .ring_indicate,
   .card_supply_request, .prog_voltage_request, .socket_power_state,
   .power_req_update, .status_change_bus_irq, .legacy_irq);
`default_nettype wire

// [test/test_pc_card_socket_power_irq_control.sv]
// Self-checking bench for the socket power and interrupt registers
`timescale 1ns/10ps
`default_nettype none
module test_pc_card_socket_power_irq_control;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic global_reset_in_n = 1'b1;
   logic bus_reset_in_n = 1'b1;
   logic power_event_enable = 1'b1;
   logic change_route_ctrl = 1'b1;
   logic [11:0] reg_addr = 12'h000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [1:0] want_32 = 2'h0, want_ring = 2'h0;
   logic [1:0] want_irq = 2'h0, want_chg = 2'h0;
   logic [7:0] reg_rdata;
   logic reg_ack, system_mgmt_interrupt;
   logic [1:0] card_is_32bit, battery_ring_pin, card_ireq_n;
   logic [1:0] card_status_change, card_output_enable, card_reset_out;
   logic [1:0] card_kind_select, ring_indicate, socket_power_state;
   logic [1:0] power_req_update, status_change_bus_route;
   logic [1:0] status_change_bus_irq;
   logic [3:0] card_supply_request, prog_voltage_request;
   logic [15:0] legacy_irq;
   int n_mismatch = 0;
   int checked = 0;
   int n;
   // Address, write data, read back, supply and programming requests
   logic [35:0] rows [11] = '{
      {12'h802, 8'hFF, 8'h9B, 4'h3, 4'h0}, {12'h802, 8'h0A, 8'h0A, 4'h0, 4'h0},
      {12'h802, 8'h12, 8'h12, 4'h2, 4'h2}, {12'h802, 8'h19, 8'h19, 4'h3, 4'h1},
      {12'h842, 8'h10, 8'h10, 4'hB, 4'h1}, {12'h802, 8'h00, 8'h00, 4'h8, 4'h0},
      {12'h841, 8'hFF, 8'h40, 4'h8, 4'h0}, {12'h803, 8'hFF, 8'hFF, 4'h8, 4'h0},
      {12'h843, 8'h5A, 8'h5A, 4'h8, 4'h0}, {12'h804, 8'h77, 8'h00, 4'h8, 4'h0},
      {12'h8C2, 8'h55, 8'h00, 4'h8, 4'h0}};
   // Routing control, register value, expected bus routing
   logic [9:0] routes [4] = '{{1'b0, 8'h71, 1'b1}, {1'b0, 8'h61, 1'b0},
      {1'b1, 8'h71, 1'b0}, {1'b1, 8'h60, 1'b1}};

   always #20 clk = ~clk;

   socket_power_irq_ctrl dut_u (.clk, .rst_n, .global_reset_in_n,
      .bus_reset_in_n, .power_event_enable, .change_route_ctrl, .reg_addr,
      .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_ack, .card_is_32bit,
      .battery_ring_pin, .card_ireq_n, .card_status_change,
      .card_output_enable, .card_reset_out, .card_kind_select,
      .ring_indicate, .card_supply_request, .prog_voltage_request,
      .socket_power_state, .power_req_update, .status_change_bus_route,
      .status_change_bus_irq, .legacy_irq, .system_mgmt_interrupt);
   card_model card_u (.want_32, .want_ring, .want_irq, .want_chg,
      .card_reset_out, .card_is_32bit, .battery_ring_pin, .card_ireq_n,
      .card_status_change);

   task tick(input int k);
      repeat (k) @(negedge clk);
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // The answer lands one edge after the request edge
   task acc(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = w;
      reg_rd = ~w;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      chk(16'(reg_ack), 16'h1);
   endtask
   task rdchk(input logic [11:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk(16'(reg_rdata), 16'(e));
   endtask
   // Margin after release covers the pin synchronisers
   task pulse(input logic g);
      @(negedge clk);
      global_reset_in_n = ~g;
      bus_reset_in_n = g;
      tick(5);
      global_reset_in_n = 1'b1;
      bus_reset_in_n = 1'b1;
      tick(4);
   endtask
   task close_out;
      if (n_mismatch == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      tick(8);
      rst_n = 1'b1;
      tick(3);
      rdchk(12'h802, 8'h00);
      rdchk(12'h803, 8'h00);
      chk(16'(card_reset_out), 16'h3);
      for (n = 0; n < 11; n++)
      begin
         acc(1'b1, rows[n][35:24], rows[n][23:16]);
         rdchk(rows[n][35:24], rows[n][15:8]);
         chk(16'(card_supply_request), 16'(rows[n][7:4]));
         chk(16'(prog_voltage_request), 16'(rows[n][3:0]));
      end
      acc(1'b1, 12'h802, 8'h80);
      tick(1);
      chk(16'(power_req_update), 16'h0);
      tick(1);
      chk(16'(card_output_enable), 16'h1);
      // Supply change on socket 1 gives a single update pulse
      acc(1'b1, 12'h842, 8'h18);
      tick(1);
      chk(16'(power_req_update), 16'h2);
      chk(16'(socket_power_state), 16'h2);
      tick(1);
      chk(16'(power_req_update), 16'h0);
      want_irq = 2'h1;
      for (n = 0; n < 16; n++)
      begin
         acc(1'b1, 12'h803, 8'h60 | 8'(n));
         tick(4);
         chk(legacy_irq, (n == 0 || n == 2) ? 16'h0 : 16'h1 << n);
         chk(16'(system_mgmt_interrupt), 16'(n == 2));
         chk(16'(card_kind_select), 16'h1);
      end
      want_chg = 2'h1;
      for (n = 0; n < 4; n++)
      begin
         change_route_ctrl = routes[n][9];
         acc(1'b1, 12'h803, routes[n][8:1]);
         tick(3);
         chk(16'(status_change_bus_route[0]), 16'(routes[n][0]));
         chk(16'(status_change_bus_irq[0]), 16'(routes[n][0]));
      end
      want_ring = 2'h1;
      acc(1'b1, 12'h803, 8'h80);
      tick(4);
      chk(16'(ring_indicate), 16'h1);
      chk(16'(card_reset_out), 16'h1);
      want_32 = 2'h1;
      tick(4);
      chk(16'(card_reset_out), 16'h0);
      acc(1'b1, 12'h802, 8'h9B);
      acc(1'b1, 12'h803, 8'hFF);
      pulse(1'b0);
      rdchk(12'h802, 8'h9B);
      rdchk(12'h803, 8'h60);
      power_event_enable = 1'b0;
      tick(4);
      pulse(1'b0);
      rdchk(12'h802, 8'h00);
      power_event_enable = 1'b1;
      acc(1'b1, 12'h802, 8'h9B);
      pulse(1'b1);
      rdchk(12'h802, 8'h00);
      // Mid-run reset drops a live socket back to defaults
      acc(1'b1, 12'h842, 8'h98);
      tick(2);
      chk(16'(card_output_enable), 16'h2);
      rst_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      tick(3);
      rdchk(12'h842, 8'h00);
      chk(16'(card_output_enable), 16'h0);
      chk(16'(card_reset_out), 16'h2);
      close_out;
   end
endmodule
`default_nettype wire
